// >>> include/wut_regs.vh
// Purpose: register map, field positions and timing counts of the wake-up timer
// Assumes: 8-bit register data on a plain strobe port, 100 MHz system clock
// Notes:   all registers reset to zero
`ifndef WUT_REGS_VH
`define WUT_REGS_VH

// register offsets
`define WUT_ADDR_W          8
`define WUT_OFS_CTRL        8'h32
`define WUT_OFS_AM_CFG      8'h33
`define WUT_OFS_AM_REF      8'h34
`define WUT_OFS_PM_CFG      8'h40
`define WUT_OFS_PM_REF      8'h41
`define WUT_OFS_IRQ_STAT    8'h42
`define WUT_OFS_IRQ_MASK    8'h43
`define WUT_OFS_AM_RES      8'h44
`define WUT_OFS_PM_RES      8'h45
`define WUT_OFS_ENABLE      8'h46

// wakeup_timer_ctrl fields
`define WUT_CTRL_RANGE      7
`define WUT_CTRL_CODE_HI    6
`define WUT_CTRL_CODE_LO    4
`define WUT_CTRL_IRQ_TO     3
`define WUT_CTRL_AM_TO      2
`define WUT_CTRL_PM_TO      1
`define WUT_CTRL_RSVD_MASK  8'hfe

// delta threshold fields of the measurement configuration registers
`define WUT_DELTA_HI        7
`define WUT_DELTA_LO        4

// interrupt status / mask bits
`define WUT_IRQ_TIMER       0
`define WUT_IRQ_AM          1
`define WUT_IRQ_PM          2
`define WUT_IRQ_W           3

// enable register
`define WUT_EN_BIT          0

// reset value of every register
`define WUT_RST_VAL         8'h00

// timing
`define WUT_CLK_PERIOD_NS   10
`define WUT_MS_TIME_NS      1000000
`define WUT_MS_CYCLES       (`WUT_MS_TIME_NS / `WUT_CLK_PERIOD_NS)
`define WUT_BASE_LONG_MS    10'h064
`define WUT_BASE_SHORT_MS   10'h00a

`endif

// >>> logic/wut_top.v
// Purpose: periodic wake-up timer with timed amplitude and phase measurement triggers
// Assumes: measurement engines run on sys_clk and answer each start with one done pulse
// Notes:   registers on a plain strobe port, read data one cycle after the read strobe
//
// Function
// - the base period is 100 ms when the range bit is 0 and 10 ms when it is 1.
// - the wake-up period is the base times the 3-bit timeout code plus one.
// - with the every-timeout bit set, each expiry raises the timer interrupt.
// - with the amplitude bit set, each expiry that finds the amplitude channel idle starts an amplitude measurement.
// - the amplitude interrupt fires only when a timed result differs from its reference by more than the delta.
// - with the phase bit set, each expiry that finds the phase channel idle starts a phase measurement.
// - the phase interrupt fires only when a timed result differs from its reference by more than the delta.
// - the control register sits at 32h, is read/write, resets to zero, and bit 0 is reserved.
// - the amplitude delta comes from the 4-bit threshold field of the amplitude configuration register.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "wut_regs.vh"

module wut_top #(
    parameter MS_CYCLES = `WUT_MS_CYCLES
) (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rstn,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // amplitude measurement engine
    output reg        amp_meas_start,
    input  wire       amp_meas_done,
    input  wire [7:0] amp_meas_val,
    // phase measurement engine
    output reg        phs_meas_start,
    input  wire       phs_meas_done,
    input  wire [7:0] phs_meas_val,
    // interrupt and status
    output reg        irq,
    output reg        wakeup_expire
);

    // prescaler width holds the default count of one millisecond
    localparam             CNT_W     = 20;
    localparam             MS_W      = 10;
    localparam integer     MS_LAST_I = MS_CYCLES - 1;
    localparam [CNT_W-1:0] MS_LAST   = MS_LAST_I[CNT_W-1:0];

    // measurement channel states, one-hot
    localparam [2:0]       CH_IDLE   = 3'h1;
    localparam [2:0]       CH_START  = 3'h2;
    localparam [2:0]       CH_BUSY   = 3'h4;

    // register file
    reg  [7:0]            ctrl_r;
    reg  [7:0]            am_cfg_r;
    reg  [7:0]            am_ref_r;
    reg  [7:0]            pm_cfg_r;
    reg  [7:0]            pm_ref_r;
    reg  [`WUT_IRQ_W-1:0] irq_stat_r;
    reg  [`WUT_IRQ_W-1:0] irq_mask_r;
    reg                   enable_r;

    // timer state
    reg  [CNT_W-1:0]      cyc_cnt_r;
    reg  [MS_W-1:0]       ms_cnt_r;
    reg  [MS_W-1:0]       period_ms;
    reg  [MS_W-1:0]       base_ms;
    wire                  ms_tick;
    wire                  expire;
    wire                  restart;

    // measurement channels: index 0 amplitude, 1 phase
    wire [1:0]            ch_on;
    wire [1:0]            ch_done;
    wire [15:0]           ch_val;
    wire [15:0]           ch_ref;
    wire [7:0]            ch_delta;
    wire [1:0]            ch_start;
    wire [1:0]            ch_busy;
    wire [15:0]           ch_res;
    wire [1:0]            ch_chg;

    // interrupt logic
    wire [`WUT_IRQ_W-1:0] irq_set;
    wire [`WUT_IRQ_W-1:0] irq_clr;
    wire [`WUT_IRQ_W-1:0] irq_stat_nxt;

    // write decode, one strobe per register
    wire                  wr_ctrl;
    wire                  wr_am_cfg;
    wire                  wr_am_ref;
    wire                  wr_pm_cfg;
    wire                  wr_pm_ref;
    wire                  wr_stat;
    wire                  wr_mask;
    wire                  wr_en;

    // next values of the counters, the read port and the interrupt level
    reg  [CNT_W-1:0]      cyc_cnt_nxt;
    reg  [MS_W-1:0]       ms_cnt_nxt;
    reg  [7:0]            rdata_nxt;
    wire                  irq_nxt;

    // the strobe and the offset are decoded in the same cycle
    assign wr_ctrl   = reg_wr && (reg_addr == `WUT_OFS_CTRL);
    assign wr_am_cfg = reg_wr && (reg_addr == `WUT_OFS_AM_CFG);
    assign wr_am_ref = reg_wr && (reg_addr == `WUT_OFS_AM_REF);
    assign wr_pm_cfg = reg_wr && (reg_addr == `WUT_OFS_PM_CFG);
    assign wr_pm_ref = reg_wr && (reg_addr == `WUT_OFS_PM_REF);
    assign wr_stat   = reg_wr && (reg_addr == `WUT_OFS_IRQ_STAT);
    assign wr_mask   = reg_wr && (reg_addr == `WUT_OFS_IRQ_MASK);
    assign wr_en     = reg_wr && (reg_addr == `WUT_OFS_ENABLE);

    // control register; bit 0 is reserved and never stores
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= `WUT_RST_VAL;
        end else if (wr_ctrl) begin
            ctrl_r <= reg_wdata & `WUT_CTRL_RSVD_MASK;
        end
    end

    // measurement thresholds and references
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            am_cfg_r <= `WUT_RST_VAL;
            am_ref_r <= `WUT_RST_VAL;
            pm_cfg_r <= `WUT_RST_VAL;
            pm_ref_r <= `WUT_RST_VAL;
        end else begin
            if (wr_am_cfg) begin
                am_cfg_r <= reg_wdata;
            end
            if (wr_am_ref) begin
                am_ref_r <= reg_wdata;
            end
            if (wr_pm_cfg) begin
                pm_cfg_r <= reg_wdata;
            end
            if (wr_pm_ref) begin
                pm_ref_r <= reg_wdata;
            end
        end
    end

    // interrupt mask and wake-up enable; the timer idles until enabled
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_r <= {`WUT_IRQ_W{1'b0}};
            enable_r   <= 1'b0;
        end else begin
            if (wr_mask) begin
                irq_mask_r <= reg_wdata[`WUT_IRQ_W-1:0];
            end
            if (wr_en) begin
                enable_r <= reg_wdata[`WUT_EN_BIT];
            end
        end
    end

    // base period and period length in milliseconds
    always @* begin
        if (ctrl_r[`WUT_CTRL_RANGE]) begin
            base_ms = `WUT_BASE_SHORT_MS;
        end else begin
            base_ms = `WUT_BASE_LONG_MS;
        end
        // base times code plus one; 800 fits in ten bits
        period_ms = base_ms * ({7'h00, ctrl_r[`WUT_CTRL_CODE_HI:`WUT_CTRL_CODE_LO]}
                    + 10'h001);
    end

    // a new setting takes effect from a fresh count, so an old partial period
    // never combines with a shorter new one into a surprise early expiry
    assign restart = wr_ctrl || wr_en || !enable_r;
    assign ms_tick = (cyc_cnt_r == MS_LAST);
    assign expire  = enable_r && ms_tick && (ms_cnt_r == period_ms - 10'h001);

    // next prescaler and period count; a restart wins over a tick
    always @* begin
        cyc_cnt_nxt = cyc_cnt_r + 20'h00001;
        ms_cnt_nxt  = ms_cnt_r;
        if (restart) begin
            cyc_cnt_nxt = {CNT_W{1'b0}};
            ms_cnt_nxt  = {MS_W{1'b0}};
        end else if (ms_tick) begin
            cyc_cnt_nxt = {CNT_W{1'b0}};
            if (expire) begin
                ms_cnt_nxt = {MS_W{1'b0}};
            end else begin
                ms_cnt_nxt = ms_cnt_r + 10'h001;
            end
        end
    end

    // millisecond prescaler and period counter
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cyc_cnt_r <= {CNT_W{1'b0}};
            ms_cnt_r  <= {MS_W{1'b0}};
        end else begin
            cyc_cnt_r <= cyc_cnt_nxt;
            ms_cnt_r  <= ms_cnt_nxt;
        end
    end

    // per-channel inputs packed for the generate loop
    assign ch_on    = {ctrl_r[`WUT_CTRL_PM_TO], ctrl_r[`WUT_CTRL_AM_TO]};
    assign ch_done  = {phs_meas_done, amp_meas_done};
    assign ch_val   = {phs_meas_val, amp_meas_val};
    assign ch_ref   = {pm_ref_r, am_ref_r};
    assign ch_delta = {pm_cfg_r[`WUT_DELTA_HI:`WUT_DELTA_LO],
                       am_cfg_r[`WUT_DELTA_HI:`WUT_DELTA_LO]};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
            wire [7:0] val;
            wire [7:0] ref_v;
            wire [7:0] diff;
            wire       accept;
            reg  [2:0] state_r;
            reg  [2:0] state_nxt;
            reg  [7:0] res_r;

            // absolute difference, so a drop and a rise count alike
            assign val   = ch_val[gi*8 +: 8];
            assign ref_v = ch_ref[gi*8 +: 8];
            assign diff  = (val >= ref_v) ? (val - ref_v) : (ref_v - val);
            // only results of measurements this timer started are taken
            assign accept     = (state_r == CH_BUSY) && ch_done[gi];
            assign ch_chg[gi] = accept
                                && (diff > {4'h0, ch_delta[gi*4 +: 4]});
            // channel view for the outputs and the read port
            assign ch_start[gi]      = (state_r == CH_START);
            assign ch_busy[gi]       = (state_r == CH_BUSY);
            assign ch_res[gi*8 +: 8] = res_r;

            // next state; an expiry during a running measurement starts nothing
            always @* begin
                case (state_r)
                    CH_IDLE: begin
                        if (expire && ch_on[gi]) begin
                            state_nxt = CH_START;
                        end else begin
                            state_nxt = CH_IDLE;
                        end
                    end
                    // one cycle that launches the start pulse
                    CH_START: begin
                        state_nxt = CH_BUSY;
                    end
                    // a lost done pulse keeps the channel busy until reset
                    CH_BUSY: begin
                        if (ch_done[gi]) begin
                            state_nxt = CH_IDLE;
                        end else begin
                            state_nxt = CH_BUSY;
                        end
                    end
                    default: begin
                        state_nxt = CH_IDLE;
                    end
                endcase
            end

            // channel state and the last accepted result
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    state_r <= CH_IDLE;
                    res_r   <= 8'h00;
                end else begin
                    state_r <= state_nxt;
                    if (accept) begin
                        res_r <= val;
                    end
                end
            end
        end
    endgenerate

    // sticky status; a set in the clearing cycle wins
    assign irq_set = {ch_chg[1], ch_chg[0],
                      expire && ctrl_r[`WUT_CTRL_IRQ_TO]};
    assign irq_clr = wr_stat ? reg_wdata[`WUT_IRQ_W-1:0] : {`WUT_IRQ_W{1'b0}};
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;

    // the level follows the status bits of the same edge
    assign irq_nxt = |(irq_stat_nxt & irq_mask_r);

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_r <= {`WUT_IRQ_W{1'b0}};
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // outputs, all registered
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq            <= 1'b0;
            wakeup_expire  <= 1'b0;
            amp_meas_start <= 1'b0;
            phs_meas_start <= 1'b0;
        end else begin
            irq            <= irq_nxt;
            wakeup_expire  <= expire;
            amp_meas_start <= ch_start[0];
            phs_meas_start <= ch_start[1];
        end
    end

    // read multiplexer; unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `WUT_OFS_CTRL:     rdata_nxt = ctrl_r;
            `WUT_OFS_AM_CFG:   rdata_nxt = am_cfg_r;
            `WUT_OFS_AM_REF:   rdata_nxt = am_ref_r;
            `WUT_OFS_PM_CFG:   rdata_nxt = pm_cfg_r;
            `WUT_OFS_PM_REF:   rdata_nxt = pm_ref_r;
            `WUT_OFS_IRQ_STAT: rdata_nxt = {5'h00, irq_stat_r};
            `WUT_OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
            `WUT_OFS_AM_RES:   rdata_nxt = ch_res[7:0];
            `WUT_OFS_PM_RES:   rdata_nxt = ch_res[15:8];
            `WUT_OFS_ENABLE:   rdata_nxt = {6'h00, ch_busy != 2'b00, enable_r};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // read data stands one cycle after the strobe and is zero otherwise
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// >>> sim/wut_top_assertions.sv
// Purpose: port-level checks of the wake-up timer
// Assumes: MS_CYCLES equals that of the bound instance
// Notes:   attached by the bind after the module
`timescale 1ns/100ps
`include "wut_regs.vh"
module wut_chk #(parameter MS_CYCLES = 10) (
    // clock and reset
    input wire       sys_clk,
    input wire       rstn,
    // register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // measurement engines
    input wire       amp_meas_start,
    input wire       amp_meas_done,
    input wire [7:0] amp_meas_val,
    input wire       phs_meas_start,
    input wire       phs_meas_done,
    input wire [7:0] phs_meas_val,
    // interrupt and status
    input wire       irq,
    input wire       wakeup_expire
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    reg [31:0] gap_r;
    reg        seen_r;
    // cycles since last expiry; a restart only ever lengthens the gap
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            gap_r  <= 32'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r  <= wakeup_expire ? 32'h1 : gap_r + 32'h1;
            seen_r <= seen_r | wakeup_expire;
        end
    end
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    AST_RSVD_BIT0: assert property ($past(reg_rd) && $past(reg_addr) == `WUT_OFS_CTRL
        |-> !reg_rdata[0]) else $error("reserved control bit reads one");
    AST_EXPIRE_PULSE: assert property (wakeup_expire |=> !wakeup_expire)
        else $error("expiry pulse longer than one cycle");
    AST_EXPIRE_GAP: assert property (wakeup_expire && seen_r |-> gap_r >= 10 * MS_CYCLES)
        else $error("expiry sooner than shortest period");
    AST_AMP_START: assert property ($rose(amp_meas_start) |-> $past(wakeup_expire))
        else $error("amplitude start without expiry");
    AST_PHS_START: assert property ($rose(phs_meas_start) |-> $past(wakeup_expire))
        else $error("phase start without expiry");
    AST_START_PULSE: assert property (amp_meas_start |=> !amp_meas_start)
        else $error("amplitude start longer than one cycle");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> wakeup_expire ||
        $past(amp_meas_done) || $past(phs_meas_done) || $past(reg_wr, 2))
        else $error("interrupt rose without a cause");
    COV_EXPIRE: cover property (wakeup_expire);
    COV_IRQ: cover property ($rose(irq));
    COV_AMP: cover property (amp_meas_start);
endmodule
bind wut_top wut_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .amp_meas_start(amp_meas_start), .amp_meas_done(amp_meas_done),
    .amp_meas_val(amp_meas_val), .phs_meas_start(phs_meas_start),
    .phs_meas_done(phs_meas_done), .phs_meas_val(phs_meas_val), .irq(irq),
    .wakeup_expire(wakeup_expire));

// >>> sim/tb.sv
// Purpose: self-checking bench of the wake-up timer
// Assumes: MS_CYCLES of 10 keeps the tested periods between 100 and 1000 cycles
// Notes:   read results are queued and compared by a watcher
`timescale 1ns/100ps
`include "wut_regs.vh"
module tb;
    reg        sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, meas_val = 8'h00;
    reg        amp_done = 1'b0, phs_done = 1'b0, rd_seen = 1'b0;
    wire [7:0] reg_rdata;
    wire       amp_start, phs_start, irq, wakeup_expire;
    logic [7:0] exp_q[$];
    int err_count = 0, compares = 0;
    wut_top #(.MS_CYCLES(10)) uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .amp_meas_start(amp_start), .amp_meas_done(amp_done), .amp_meas_val(meas_val),
        .phs_meas_start(phs_start), .phs_meas_done(phs_done), .phs_meas_val(meas_val),
        .irq(irq), .wakeup_expire(wakeup_expire));
    initial forever #5 sys_clk = ~sys_clk;
    task chk(input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask
    task stop_test;
        $display("errors=%0d compares=%0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    // expected value is queued; the watcher compares the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a; reg_rd <= 1'b1; exp_q.push_back(e);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    always @(posedge sys_clk) rd_seen <= reg_rd;
    always @(negedge sys_clk) if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    // bounded wait on a settled signal; a hang ends the run
    task wait_on(input int which, output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while ((which == 0 ? wakeup_expire : which == 1 ? amp_start : phs_start) !== 1'b1
            && n < 3000);
        if (n >= 3000) begin err_count++; stop_test; end
    endtask
    task meas(input logic ch, input int d, input logic over);
        int n, r;
        logic [7:0] v;
        r = $urandom_range(200, 40);
        v = over ? r - d - 1 : r + d;
        wr(ch ? `WUT_OFS_PM_CFG : `WUT_OFS_AM_CFG, d << 4);
        wr(ch ? `WUT_OFS_PM_REF : `WUT_OFS_AM_REF, r);
        wr(`WUT_OFS_IRQ_STAT, 8'h07);
        wr(`WUT_OFS_CTRL, ch ? 8'hf2 : 8'hf4); // long period: one start per call
        wait_on(ch ? 2 : 1, n);
        rd(`WUT_OFS_ENABLE, 8'h03);
        repeat (3) @(posedge sys_clk);
        amp_done <= !ch; phs_done <= ch; meas_val <= v;
        @(posedge sys_clk);
        amp_done <= 1'b0; phs_done <= 1'b0; meas_val <= ~v;
        repeat (3) @(posedge sys_clk);
        #1 chk(irq, over);
        rd(`WUT_OFS_IRQ_STAT, over ? (ch ? 8'h04 : 8'h02) : 8'h00);
        rd(ch ? `WUT_OFS_PM_RES : `WUT_OFS_AM_RES, v);
        rd(`WUT_OFS_ENABLE, 8'h01);
        wr(`WUT_OFS_CTRL, 8'h00);
        $display("measure test ch=%0d over=%0d done", ch, over);
    endtask
    logic [7:0] ctl [4] = '{8'h88, 8'hf8, 8'h08, 8'h80};
    int per [4] = '{100, 800, 1000, 100};
    initial begin
        int n, i;
        logic [7:0] x;
        void'($urandom(32'h096a));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`WUT_OFS_CTRL, 8'h00);
        x = $urandom;
        wr(`WUT_OFS_CTRL, x);
        rd(`WUT_OFS_CTRL, x & `WUT_CTRL_RSVD_MASK);
        rd(8'h35, 8'h00);
        $display("register test done");
        wr(`WUT_OFS_IRQ_MASK, 8'h07);
        wr(`WUT_OFS_ENABLE, 8'h01);
        for (i = 0; i < 4; i++) begin
            wr(`WUT_OFS_CTRL, ctl[i]);
            wr(`WUT_OFS_IRQ_STAT, 8'h07);
            wait_on(0, n);
            wait_on(0, n);
            chk(n, per[i]);
            rd(`WUT_OFS_IRQ_STAT, {7'h0, ctl[i][3]});
            #1 chk(irq, ctl[i][3]);
            $display("period test %0d done", i);
        end
        for (i = 0; i < 4; i++) meas(i[1], $urandom % 16, i[0]);
        stop_test;
    end
endmodule
